// >>> rtl/bic_pkg.sv
// Constants shared by the breaker interface command block and its clock.
// Assumes register addresses are zero based Modbus addresses (register-1).
package bic_pkg;

  // Command block, registers 8000 to 8038
  localparam logic [15:0] REG_CMD_CODE    = 16'h1F3F;
  localparam logic [15:0] REG_BYTE_COUNT  = 16'h1F40;
  localparam logic [15:0] REG_DESTINATION = 16'h1F41;
  localparam logic [15:0] REG_SECURITY    = 16'h1F42;
  localparam logic [15:0] REG_PASSWORD    = 16'h1F43;
  localparam logic [15:0] REG_DATETIME    = 16'h1F45;
  localparam int unsigned CMD_WORDS       = 39;
  // Word indices inside the command block
  localparam int unsigned IDX_CODE  = 0;
  localparam int unsigned IDX_COUNT = 1;
  localparam int unsigned IDX_DEST  = 2;
  localparam int unsigned IDX_SEC   = 3;
  localparam int unsigned IDX_PW_HI = 4;
  localparam int unsigned IDX_PW_LO = 5;
  localparam int unsigned IDX_PARAM = 6;
  localparam int unsigned IDX_NAME  = 9;

  // Result registers 8021 and 8022, time readback 8023 to 8026
  localparam logic [15:0] REG_LAST_CODE = 16'h1F54;
  localparam logic [15:0] REG_ERROR     = 16'h1F55;
  localparam logic [15:0] REG_TIME_BASE = 16'h1F56;
  localparam int unsigned TIME_WORDS    = 4;

  // User application name, registers 10242 to 10273
  localparam logic [15:0] REG_NAME_BASE = 16'h2801;
  localparam int unsigned NAME_REGS     = 32;
  localparam int unsigned NAME_WORDS    = 24;

  // Command codes
  localparam logic [15:0] CMD_GET_TIME    = 16'h0300;
  localparam logic [15:0] CMD_SET_TIME    = 16'h0301;
  localparam logic [15:0] CMD_WRITE_NAME  = 16'h0408;
  localparam logic [15:0] CMD_ALARM_RESET = 16'hA08B;
  localparam logic [15:0] CMD_CRADLE_PRE  = 16'hA188;
  localparam logic [15:0] CMD_REGREASE    = 16'hA189;
  localparam logic [15:0] CMD_GET_EVENTS  = 16'hC580;

  // Fixed fields of the commands
  localparam logic [15:0] CNT_GET_TIME    = 16'h000A;
  localparam logic [15:0] CNT_SET_TIME    = 16'h0012;
  localparam logic [15:0] CNT_ALARM_RESET = 16'h000A;
  localparam logic [15:0] CNT_CRADLE_PRE  = 16'h0010;
  localparam logic [15:0] CNT_REGREASE    = 16'h0012;
  localparam logic [15:0] CNT_GET_EVENTS  = 16'h001B;
  localparam logic [15:0] CNT_NAME_MIN    = 16'h0007;
  localparam logic [15:0] CNT_NAME_MAX    = 16'h0035;
  localparam logic [15:0] DEST_ALL_UNITS  = 16'h2200;
  localparam logic [15:0] DEST_IFACE      = 16'h2201;
  localparam logic [15:0] DEST_NONE       = 16'h0000;
  localparam logic [15:0] SEC_OPEN        = 16'h0000;
  localparam logic [15:0] SEC_PROFILE     = 16'h0001;
  localparam logic [31:0] PW_NONE         = 32'h0000_0000;
  localparam logic [15:0] NAME_HDR0       = 16'h0104;
  localparam logic [15:0] NAME_HDR1       = 16'h0081;
  localparam logic [15:0] NAME_HDR2       = 16'h0800;

  // Generic error codes reported in the error register
  localparam logic [15:0] ERR_NONE      = 16'h0000;
  localparam logic [15:0] ERR_UNKNOWN   = 16'h0001;
  localparam logic [15:0] ERR_PARAM     = 16'h0002;
  localparam logic [15:0] ERR_PASSWORD  = 16'h0003;
  localparam logic [15:0] ERR_LOCKED    = 16'h0004;

  // Time base: one millisecond at a 4 ns clock
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

  // Calendar reset point, 1 January of year offset 0
  localparam logic [3:0] RESET_MONTH = 4'h1;
  localparam logic [4:0] RESET_DAY   = 5'h01;

endpackage

// >>> rtl/bic_rtc.sv
// Date and time counter with millisecond resolution.
// Assumes one clock; load and battery loss are synchronous levels/pulses.
`timescale 1ns/1ps
`default_nettype none

module bic_rtc #(
  parameter int unsigned CYCLES_PER_MS = bic_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Control
  input  wire logic        load_i,
  input  wire logic        battery_lost_i,
  input  wire logic [63:0] load_time_i,
  // Current time, words in readback order
  output logic      [63:0] time_o
);

  typedef struct packed {
    logic [31:0] div;
    logic [9:0]  ms;
    logic [5:0]  sec;
    logic [5:0]  min;
    logic [4:0]  hour;
    logic [4:0]  day;
    logic [3:0]  month;
    logic [7:0]  year;
  } bic_rtc_state_t;

  bic_rtc_state_t s_reg;
  bic_rtc_state_t s_next;
  logic [4:0]     month_days;

  // Offsets 0..99 map to 2000..2099, so every fourth year is leap
  always_comb begin
    unique case (s_reg.month)
      4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
      4'h2:                    month_days = (s_reg.year[1:0] == 2'h0) ?
                                            5'h1D : 5'h1C;
      default:                 month_days = 5'h1F;
    endcase
  end

  // Divider and calendar carry chain
  always_comb begin
    s_next = s_reg;
    if (battery_lost_i) begin
      s_next       = '0;
      s_next.day   = bic_pkg::RESET_DAY;
      s_next.month = bic_pkg::RESET_MONTH;
    end else if (load_i) begin
      s_next.div   = '0;
      s_next.month = load_time_i[59:56];
      s_next.day   = load_time_i[52:48];
      s_next.year  = load_time_i[47:40];
      s_next.hour  = load_time_i[36:32];
      s_next.min   = load_time_i[29:24];
      s_next.sec   = load_time_i[21:16];
      s_next.ms    = load_time_i[9:0];
    end else if (s_reg.div == 32'(CYCLES_PER_MS - 1)) begin
      s_next.div = '0;
      s_next.ms  = s_reg.ms + 10'h001;
      if (s_reg.ms == 10'h3E7) begin
        s_next.ms  = '0;
        s_next.sec = s_reg.sec + 6'h01;
        if (s_reg.sec == 6'h3B) begin
          s_next.sec = '0;
          s_next.min = s_reg.min + 6'h01;
          if (s_reg.min == 6'h3B) begin
            s_next.min  = '0;
            s_next.hour = s_reg.hour + 5'h01;
            if (s_reg.hour == 5'h17) begin
              s_next.hour = '0;
              s_next.day  = s_reg.day + 5'h01;
              if (s_reg.day == month_days) begin
                s_next.day   = 5'h01;
                s_next.month = s_reg.month + 4'h1;
                if (s_reg.month == 4'hC) begin
                  s_next.month = 4'h1;
                  s_next.year  = s_reg.year + 8'h01;
                end
              end
            end
          end
        end
      end
    end else begin
      s_next.div = s_reg.div + 32'h0000_0001;
    end
  end

  // State register; reset lands on the calendar start point
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg       <= '0;
      s_reg.day   <= bic_pkg::RESET_DAY;
      s_reg.month <= bic_pkg::RESET_MONTH;
    end else begin
      s_reg <= s_next;
    end
  end

  // Month/day, year/hour, minute/second, milliseconds
  assign time_o = {4'h0, s_reg.month, 3'h0, s_reg.day,
                   s_reg.year, 3'h0, s_reg.hour,
                   2'h0, s_reg.min, 2'h0, s_reg.sec,
                   6'h00, s_reg.ms};

endmodule

`default_nettype wire

// >>> rtl/bic_cmd.sv
// Command interpreter of the breaker communication interface.
// Assumes a Modbus slave front end that turns frames into register
// strobes and marks the end of each write frame with frame_end_i.
//
// What this block does
// - Time read: 768, 10 bytes, 8704, open.
// - Time returned in registers 8023 to 8026.
// - Time read runs even when pad locked.
// - Time set: 769, 18 bytes, 8704, open.
// - Time set runs even when pad locked.
// - Battery loss restarts clock at 1 January 2000.
// - Name write: 1032, destination 0, security 1.
// - Stored name readable at 10242 to 10273.
// - Recognise four interface specific command codes.
// - Failures reported with generic error codes.
`timescale 1ns/1ps
`default_nettype none

module bic_cmd #(
  parameter int unsigned CYCLES_PER_MS = bic_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Register write strobe from the Modbus slave
  input  wire logic        wr_en_i,
  input  wire logic [15:0] wr_addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        frame_end_i,
  // Register read strobe and answer
  input  wire logic        rd_en_i,
  input  wire logic [15:0] rd_addr_i,
  output logic      [15:0] rd_data_o,
  output logic             rd_valid_o,
  output logic             rd_err_o,
  // Front panel, supply and profile passwords
  input  wire logic        lock_pad_i,
  input  wire logic        battery_lost_i,
  input  wire logic [31:0] admin_pw_i,
  input  wire logic [31:0] oper_pw_i,
  // Specific command action pulses, one cycle each, and their held parameter
  output logic             alarm_reset_o,
  output logic             cradle_preset_o,
  output logic             regrease_preset_o,
  output logic             event_fetch_o,
  output logic      [63:0] action_param_o,
  // Command result
  output logic             cmd_done_o,
  output logic      [15:0] cmd_error_o
);

  typedef struct packed {
    logic [bic_pkg::CMD_WORDS-1:0][15:0]  cmd_buf;
    logic [bic_pkg::NAME_WORDS-1:0][15:0] name;
    logic [bic_pkg::TIME_WORDS-1:0][15:0] snap;
    logic [15:0] last_code;
    logic [15:0] err;
    logic        done;
    logic        time_load;
    logic [63:0] time_value;
    logic        alarm_reset;
    logic        cradle_preset;
    logic        regrease_preset;
    logic        event_fetch;
    logic [63:0] action_param;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        rd_err;
  } bic_cmd_state_t;

  bic_cmd_state_t s_reg;
  bic_cmd_state_t s_next;

  logic [63:0] rtc_time;
  logic [15:0] wr_off;
  logic [15:0] rd_off;
  logic [15:0] rd_time_off;
  logic [15:0] rd_name_off;
  logic [15:0] code;
  logic [15:0] count;
  logic [15:0] dest;
  logic [15:0] sec;
  logic [31:0] pw;
  logic [63:0] param;
  logic        open_cmd;
  logic        prof_cmd;
  logic        pw_ok;

  // Clock kept here so the time commands act on it directly
  bic_rtc #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_rtc (
    .ref_clk_i      (ref_clk_i),
    .rst_n_i        (rst_n_i),
    .load_i         (s_reg.time_load),
    .battery_lost_i (battery_lost_i),
    .load_time_i    (s_reg.time_value),
    .time_o         (rtc_time)
  );

  // Offsets of an access into each mapped window
  assign wr_off      = wr_addr_i - bic_pkg::REG_CMD_CODE;
  assign rd_off      = rd_addr_i - bic_pkg::REG_CMD_CODE;
  assign rd_time_off = rd_addr_i - bic_pkg::REG_TIME_BASE;
  assign rd_name_off = rd_addr_i - bic_pkg::REG_NAME_BASE;

  // Fields of the command block as the client left them
  assign code  = s_reg.cmd_buf[bic_pkg::IDX_CODE];
  assign count = s_reg.cmd_buf[bic_pkg::IDX_COUNT];
  assign dest  = s_reg.cmd_buf[bic_pkg::IDX_DEST];
  assign sec   = s_reg.cmd_buf[bic_pkg::IDX_SEC];
  assign pw    = {s_reg.cmd_buf[bic_pkg::IDX_PW_HI],
                  s_reg.cmd_buf[bic_pkg::IDX_PW_LO]};
  assign param = {s_reg.cmd_buf[bic_pkg::IDX_PARAM],
                  s_reg.cmd_buf[bic_pkg::IDX_PARAM+1],
                  s_reg.cmd_buf[bic_pkg::IDX_PARAM+2],
                  s_reg.cmd_buf[bic_pkg::IDX_PARAM+3]};

  // Open commands carry security type 0 and an all zero password
  assign open_cmd = (sec == bic_pkg::SEC_OPEN) && (pw == bic_pkg::PW_NONE);
  // Profile commands: a zero password never matches a profile
  assign prof_cmd = (sec == bic_pkg::SEC_PROFILE);
  assign pw_ok    = (pw != bic_pkg::PW_NONE) &&
                    ((pw == admin_pw_i) || (pw == oper_pw_i));

  // Command buffer writes, command execution and register reads
  always_comb begin
    s_next = s_reg;
    // Action strobes last a single cycle
    s_next.time_load       = 1'b0;
    s_next.done            = 1'b0;
    s_next.alarm_reset     = 1'b0;
    s_next.cradle_preset   = 1'b0;
    s_next.regrease_preset = 1'b0;
    s_next.event_fetch     = 1'b0;
    s_next.rd_valid        = 1'b0;
    s_next.rd_err          = 1'b0;

    // Client fills the block; writes elsewhere are ignored
    if (wr_en_i && (wr_off < 16'(bic_pkg::CMD_WORDS))) begin
      s_next.cmd_buf[wr_off[5:0]] = wr_data_i;
    end

    // Execute the block once the write frame has closed
    if (frame_end_i) begin
      s_next.done      = 1'b1;
      s_next.last_code = code;
      s_next.err       = bic_pkg::ERR_NONE;
      unique case (code)
        bic_pkg::CMD_GET_TIME: begin
          // No lock check: this command is not hardware protected
          if (count == bic_pkg::CNT_GET_TIME &&
              dest == bic_pkg::DEST_ALL_UNITS && open_cmd) begin
            s_next.snap = rtc_time;
          end else begin
            s_next.err = bic_pkg::ERR_PARAM;
          end
        end
        bic_pkg::CMD_SET_TIME: begin
          // Still accepted with the pad locked
          if (count == bic_pkg::CNT_SET_TIME &&
              dest == bic_pkg::DEST_ALL_UNITS && open_cmd) begin
            s_next.time_load  = 1'b1;
            s_next.time_value = param;
          end else begin
            s_next.err = bic_pkg::ERR_PARAM;
          end
        end
        bic_pkg::CMD_WRITE_NAME: begin
          if (lock_pad_i) begin
            s_next.err = bic_pkg::ERR_LOCKED;
          end else if (dest == bic_pkg::DEST_NONE && prof_cmd &&
                       count >= bic_pkg::CNT_NAME_MIN &&
                       count <= bic_pkg::CNT_NAME_MAX &&
                       param[63:48] == bic_pkg::NAME_HDR0 &&
                       param[47:32] == bic_pkg::NAME_HDR1 &&
                       param[31:16] == bic_pkg::NAME_HDR2) begin
            // Copy word for word, first character in the high byte
            for (int i = 0; i < bic_pkg::NAME_WORDS; i++) begin
              s_next.name[i] = s_reg.cmd_buf[bic_pkg::IDX_NAME + i];
            end
          end else begin
            s_next.err = bic_pkg::ERR_PARAM;
          end
        end
        bic_pkg::CMD_ALARM_RESET,
        bic_pkg::CMD_CRADLE_PRE,
        bic_pkg::CMD_REGREASE: begin
          if (lock_pad_i) begin
            s_next.err = bic_pkg::ERR_LOCKED;
          end else if (!prof_cmd || dest != bic_pkg::DEST_IFACE ||
                       (code == bic_pkg::CMD_ALARM_RESET &&
                        count != bic_pkg::CNT_ALARM_RESET) ||
                       (code == bic_pkg::CMD_CRADLE_PRE &&
                        count != bic_pkg::CNT_CRADLE_PRE) ||
                       (code == bic_pkg::CMD_REGREASE &&
                        count != bic_pkg::CNT_REGREASE)) begin
            s_next.err = bic_pkg::ERR_PARAM;
          end else if (!pw_ok) begin
            s_next.err = bic_pkg::ERR_PASSWORD;
          end else begin
            s_next.action_param    = param;
            s_next.alarm_reset     = (code == bic_pkg::CMD_ALARM_RESET);
            s_next.cradle_preset   = (code == bic_pkg::CMD_CRADLE_PRE);
            s_next.regrease_preset = (code == bic_pkg::CMD_REGREASE);
          end
        end
        bic_pkg::CMD_GET_EVENTS: begin
          if (count == bic_pkg::CNT_GET_EVENTS &&
              dest == bic_pkg::DEST_IFACE && open_cmd) begin
            s_next.action_param = param;
            s_next.event_fetch  = 1'b1;
          end else begin
            s_next.err = bic_pkg::ERR_PARAM;
          end
        end
        default: begin
          s_next.err = bic_pkg::ERR_UNKNOWN;
        end
      endcase
    end

    // Reads answer one cycle later; command block words other than 8021 to 8026 read as zero
    if (rd_en_i) begin
      s_next.rd_valid = 1'b1;
      s_next.rd_data  = '0;
      if (rd_addr_i == bic_pkg::REG_LAST_CODE) begin
        s_next.rd_data = s_reg.last_code;
      end else if (rd_addr_i == bic_pkg::REG_ERROR) begin
        s_next.rd_data = s_reg.err;
      end else if (rd_time_off < 16'(bic_pkg::TIME_WORDS)) begin
        s_next.rd_data = s_reg.snap[2'(3 - rd_time_off[1:0])];
      end else if (rd_name_off < 16'(bic_pkg::NAME_REGS)) begin
        // Words past the stored name read as zero
        if (rd_name_off < 16'(bic_pkg::NAME_WORDS)) begin
          s_next.rd_data = s_reg.name[rd_name_off[4:0]];
        end
      end else if (rd_off >= 16'(bic_pkg::CMD_WORDS)) begin
        s_next.rd_err = 1'b1;
      end
    end
  end

  // Single state register for the whole block
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign rd_data_o         = s_reg.rd_data;
  assign rd_valid_o        = s_reg.rd_valid;
  assign rd_err_o          = s_reg.rd_err;
  assign alarm_reset_o     = s_reg.alarm_reset;
  assign cradle_preset_o   = s_reg.cradle_preset;
  assign regrease_preset_o = s_reg.regrease_preset;
  assign event_fetch_o     = s_reg.event_fetch;
  assign action_param_o    = s_reg.action_param;
  assign cmd_done_o        = s_reg.done;
  assign cmd_error_o       = s_reg.err;

endmodule

`default_nettype wire

// >>> bench/bic_cmd_properties.sv
// Concurrent checks on the ports of the breaker command block.
// Assumes one clock domain and an asynchronous active low reset.
`timescale 1ns/1ps
`default_nettype none

module bic_cmd_properties (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  // Register strobes, command trigger, pad lock and passwords
  input wire logic        wr_en_i,
  input wire logic [15:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic        frame_end_i,
  input wire logic        rd_en_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic        lock_pad_i,
  input wire logic [31:0] admin_pw_i,
  input wire logic [31:0] oper_pw_i,
  // Answers of the block
  input wire logic [15:0] rd_data_o,
  input wire logic        rd_valid_o,
  input wire logic        rd_err_o,
  input wire logic        event_fetch_o,
  input wire logic        cmd_done_o,
  input wire logic [15:0] cmd_error_o
);
  logic [15:0] code_reg, cnt_reg, dest_reg, sec_reg;
  logic [31:0] pw_reg;
  logic        open_ok;
  logic        known;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Shadow of the fields that decide a command's outcome
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {code_reg, cnt_reg, dest_reg, sec_reg, pw_reg} <= 96'h0;
    end else if (wr_en_i) begin
      case (wr_addr_i)
        bic_pkg::REG_CMD_CODE:    code_reg <= wr_data_i;
        bic_pkg::REG_BYTE_COUNT:  cnt_reg <= wr_data_i;
        bic_pkg::REG_DESTINATION: dest_reg <= wr_data_i;
        bic_pkg::REG_SECURITY:    sec_reg <= wr_data_i;
        bic_pkg::REG_PASSWORD:    pw_reg[31:16] <= wr_data_i;
        bic_pkg::REG_DATETIME - 16'h0001: pw_reg[15:0] <= wr_data_i;
        default: ;
      endcase
    end
  end

  // Open commands need no profile; unknown codes are flagged apart
  assign open_ok = sec_reg == bic_pkg::SEC_OPEN && pw_reg == bic_pkg::PW_NONE;
  assign known = code_reg inside {bic_pkg::CMD_GET_TIME,
    bic_pkg::CMD_SET_TIME, bic_pkg::CMD_WRITE_NAME, bic_pkg::CMD_ALARM_RESET,
    bic_pkg::CMD_CRADLE_PRE, bic_pkg::CMD_REGREASE, bic_pkg::CMD_GET_EVENTS};

  chk_rd_answer: assert property (rd_en_i |=> rd_valid_o)
    else $error("read not answered");
  chk_rd_unmapped: assert property (rd_en_i && rd_addr_i < 16'h1F3F
    |=> rd_err_o && rd_data_o == 16'h0000) else $error("unmapped read");
  chk_name_window: assert property (rd_en_i && rd_addr_i >= 16'h2801
    && rd_addr_i <= 16'h2820 |=> !rd_err_o) else $error("name read error");
  chk_done_latency: assert property (frame_end_i |=> cmd_done_o)
    else $error("command not completed");
  chk_get_time: assert property (frame_end_i && open_ok
    && code_reg == bic_pkg::CMD_GET_TIME && cnt_reg == 16'h000A
    && dest_reg == 16'h2200 |=> cmd_error_o == 16'h0000)
    else $error("time read refused");
  chk_set_time: assert property (frame_end_i && open_ok
    && code_reg == bic_pkg::CMD_SET_TIME && cnt_reg == 16'h0012
    && dest_reg == 16'h2200 |=> cmd_error_o == 16'h0000)
    else $error("time set refused");
  chk_unknown_code: assert property (frame_end_i && !known
    |=> cmd_error_o == bic_pkg::ERR_UNKNOWN) else $error("unknown code");
  chk_bad_password: assert property (frame_end_i && !lock_pad_i
    && code_reg == bic_pkg::CMD_ALARM_RESET && cnt_reg == 16'h000A
    && dest_reg == 16'h2201 && sec_reg == 16'h0001 && pw_reg != 32'h0
    && pw_reg != admin_pw_i && pw_reg != oper_pw_i
    |=> cmd_error_o == bic_pkg::ERR_PASSWORD) else $error("password passed");
  chk_event_fetch: assert property (frame_end_i && open_ok
    && code_reg == 16'hC580 && cnt_reg == 16'h001B && dest_reg == 16'h2201
    |=> event_fetch_o) else $error("event fetch missing");
endmodule

`default_nettype wire

// >>> bench/bic_client.sv
// Modbus client model that fills the command block and reads results.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module bic_client (
  // Clock
  input  wire logic        ref_clk_i,
  // Requests to the block
  output logic             wr_en_o,
  output logic      [15:0] wr_addr_o,
  output logic      [15:0] wr_data_o,
  output logic             frame_end_o,
  output logic             rd_en_o,
  output logic      [15:0] rd_addr_o,
  // Answers of the block
  input  wire logic [15:0] rd_data_i,
  input  wire logic        rd_valid_i,
  input  wire logic        rd_err_i,
  input  wire logic        cmd_done_i,
  input  wire logic [15:0] cmd_error_i,
  input  wire logic [3:0]  act_i
);
  // Idle bus at time zero
  initial begin
    {wr_en_o, frame_end_o, rd_en_o} = 3'h0;
    {wr_addr_o, wr_data_o, rd_addr_o} = 48'h0;
  end

  // One write; released data lines flip so stale data never looks valid
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    wr_en_o = 1'h1;
    wr_addr_o = a;
    wr_data_o = d;
    @(posedge ref_clk_i) #1;
    wr_en_o = 1'h0;
    wr_data_o = ~d;
    @(posedge ref_clk_i) #1;
  endtask

  // One read; flags are {valid, error} taken with the data
  task automatic rd(input logic [15:0] a, output logic [15:0] d,
                    output logic [1:0] f);
    rd_en_o = 1'h1;
    rd_addr_o = a;
    @(posedge ref_clk_i) #1;
    rd_en_o = 1'h0;
    rd_addr_o = ~a;
    d = rd_data_i;
    f = {rd_valid_i, rd_err_i};
    @(posedge ref_clk_i) #1;
  endtask

  // First ten words of the command block, then the frame close two cycles after the last word
  task automatic run(input logic [15:0] c, n, ds, s, input logic [31:0] pw,
      input logic [63:0] p, output logic [15:0] er, output logic [4:0] ac);
    logic [15:0] w [10];
    w = '{c, n, ds, s, pw[31:16], pw[15:0],
          p[63:48], p[47:32], p[31:16], p[15:0]};
    for (int i = 0; i < 10; i++) wr(bic_pkg::REG_CMD_CODE + 16'(i), w[i]);
    frame_end_o = 1'h1;
    @(posedge ref_clk_i) #1;
    frame_end_o = 1'h0;
    er = cmd_error_i;
    ac = {cmd_done_i, act_i};
  endtask
endmodule

`default_nettype wire

// >>> bench/bic_cmd_tb.sv
// Self-checking bench for the breaker interface command block.
// Assumes bic_client drives all register traffic; 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module bic_cmd_tb;
  logic        ref_clk_i, rst_n_i, lock_pad_i, battery_lost_i;
  logic        wr_en, frame_end, rd_en, rd_valid, rd_err, cmd_done;
  logic [15:0] wr_addr, wr_data, rd_addr, rd_data, cmd_error, e, d;
  logic [31:0] admin_pw, oper_pw;
  wire  [3:0]  act;
  logic [63:0] ap;
  logic [4:0]  ac;
  logic [1:0]  f;
  logic [15:0] tx [3];
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;

  bic_cmd #(.CYCLES_PER_MS(4)) u_dut (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .wr_en_i(wr_en), .wr_addr_i(wr_addr),
    .wr_data_i(wr_data), .frame_end_i(frame_end), .rd_en_i(rd_en),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .rd_err_o(rd_err), .lock_pad_i(lock_pad_i),
    .battery_lost_i(battery_lost_i), .admin_pw_i(admin_pw),
    .oper_pw_i(oper_pw), .alarm_reset_o(act[3]), .cradle_preset_o(act[2]),
    .regrease_preset_o(act[1]), .event_fetch_o(act[0]),
    .action_param_o(ap), .cmd_done_o(cmd_done), .cmd_error_o(cmd_error));

  bic_client u_cli (.ref_clk_i(ref_clk_i), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .frame_end_o(frame_end),
    .rd_en_o(rd_en), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .rd_err_i(rd_err), .cmd_done_i(cmd_done),
    .cmd_error_i(cmd_error), .act_i(act));

  // Free running clock, 4 ns period
  initial begin
    ref_clk_i = 1'h0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Hang guard: the tests need well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp_w(input logic [15:0] g, x, input string m);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask

  task automatic cmp_f(input logic [4:0] g, x, input string m);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("BAD t=%0t %s got %b exp %b", $time, m, g, x);
    end
  endtask

  // One command with its expected error and {done, pulses}
  task automatic go(input logic [15:0] c, n, ds, s, input logic [31:0] pw,
      input logic [63:0] p, input logic [15:0] xe, input logic [4:0] xa);
    u_cli.run(c, n, ds, s, pw, p, e, ac);
    cmp_w(e, xe, "cmd error");
    cmp_f(ac, xa, "done and pulses");
  endtask

  // Read a word and check it with the {valid, error} flags
  task automatic rdc(input logic [15:0] a, x, input logic [1:0] xf);
    u_cli.rd(a, d, f);
    cmp_w(d, x, "read data");
    cmp_f(5'(f), 5'(xf), "read flags");
  endtask

  initial begin
    rst_n_i = 1'h0;
    lock_pad_i = 1'h0;
    battery_lost_i = 1'h1;
    admin_pw = 32'h1111_2222;
    oper_pw = 32'h3333_4444;
    repeat (2) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'h1;
    // Clock held by supply loss reads back 1 January, offset 0, midnight
    go(16'h0300, 16'h000A, 16'h2200, 16'h0, 32'h0, 64'h0, 16'h0,
       5'h10);
    for (int i = 0; i < 4; i++)
      rdc(16'h1F56 + 16'(i), i == 0 ? 16'h0101 : 16'h0, 2'h2);
    $display("test 1 done");
    // Set and read back time with the pad locked, set sent twice
    battery_lost_i = 1'h0;
    lock_pad_i = 1'h1;
    repeat (2) go(16'h0301, 16'h0012, 16'h2200, 16'h0, 32'h0,
      64'h0C1F_1717_0A00_0000, 16'h0, 5'h10);
    go(16'h0300, 16'h000A, 16'h2200, 16'h0, 32'h0, 64'h0, 16'h0,
       5'h10);
    tx = '{16'h0C1F, 16'h1717, 16'h0A00};
    for (int i = 0; i < 3; i++) rdc(16'h1F56 + 16'(i), tx[i], 2'h2);
    rdc(16'h1F57, 16'h1717, 2'h2);
    cmp_w(16'h07D0 + {8'h00, d[15:8]}, 16'h07E7, "year");
    $display("test 2 done");
    // Specific commands: lock, open fetch, profiles, unknown, bad count
    go(16'hA08B, 16'h000A, 16'h2201, 16'h1, admin_pw, 64'h0, 16'h4,
       5'h10);
    go(16'hC580, 16'h001B, 16'h2201, 16'h0, 32'h0, 64'h0, 16'h0,
       5'h11);
    lock_pad_i = 1'h0;
    go(16'hA08B, 16'h000A, 16'h2201, 16'h1, 32'h1, 64'h0, 16'h3,
       5'h10);
    go(16'hA08B, 16'h000A, 16'h2201, 16'h1, admin_pw, 64'h0, 16'h0,
       5'h18);
    go(16'hA188, 16'h0010, 16'h2201, 16'h1, oper_pw, 64'h0, 16'h0,
       5'h14);
    go(16'hA189, 16'h0012, 16'h2201, 16'h1, admin_pw,
       64'h1111_2222_3333_4444, 16'h0, 5'h12);
    cmp_w(ap[63:48], 16'h1111, "action param");
    go(16'h1234, 16'h000A, 16'h2200, 16'h0, 32'h0, 64'h0, 16'h1,
       5'h10);
    go(16'h0300, 16'h000B, 16'h2200, 16'h0, 32'h0, 64'h0, 16'h2,
       5'h10);
    $display("test 3 done");
    // Name "AB": bad header refused, then stored and read back
    u_cli.wr(16'h1F49, 16'h0000);
    go(16'h0408, 16'h0009, 16'h0, 16'h1, 32'h0,
       64'h0104_0081_0801_4142, 16'h2, 5'h10);
    go(16'h0408, 16'h0009, 16'h0, 16'h1, 32'h0,
       64'h0104_0081_0800_4142, 16'h0, 5'h10);
    rdc(16'h2801, 16'h4142, 2'h2);
    rdc(16'h2802, 16'h0000, 2'h2);
    rdc(16'h2820, 16'h0000, 2'h2);
    rdc(16'h0000, 16'h0000, 2'h3);
    $display("test 4 done");
    test_done();
  end
endmodule

bind bic_cmd bic_cmd_properties u_chk (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
  .wr_data_i(wr_data_i), .frame_end_i(frame_end_i), .rd_en_i(rd_en_i),
  .rd_addr_i(rd_addr_i), .lock_pad_i(lock_pad_i), .admin_pw_i(admin_pw_i),
  .oper_pw_i(oper_pw_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .rd_err_o(rd_err_o), .event_fetch_o(event_fetch_o),
  .cmd_done_o(cmd_done_o), .cmd_error_o(cmd_error_o));

`default_nettype wire
